/* File: ddrop_port.v */
// Dual-data-rate output port for two 16-bit sample channels.
// Assumes samples arrive on clk; the sampling clock is an asynchronous pin.
// The sampling clock runs well below half the system clock rate.
//
// Behaviour
// - Each 16-bit word goes out two bits per pair.
// - Odd bit of each pair leads, even follows.
// - Forwarded clock runs at sampling clock frequency.
// - One whole word per channel per clock period.
`timescale 1ns/1ps
`include "ddrop_map.vh"

module ddrop_port #(
  parameter SAMPLE_BITS = `DDROP_SAMPLE_BITS,
  parameter PAIRS       = `DDROP_PAIR_COUNT,
  parameter FIFO_DEPTH  = `DDROP_FIFO_DEPTH,
  parameter SKEW_CYCLES = `DDROP_SKEW_CYCLES
) (
  input  wire                   clk,
  input  wire                   resetn,
  input  wire                   samplingClock,
  input  wire [SAMPLE_BITS-1:0] firstChannelSample,
  input  wire [SAMPLE_BITS-1:0] secondChannelSample,
  input  wire                   sampleValid,
  output wire                   sampleReady,
  output reg  [PAIRS-1:0]       firstChannelBitPairs,
  output reg  [PAIRS-1:0]       secondChannelBitPairs,
  output reg                    forwardedWordClock,
  output reg                    sampleUnderrun
);

  localparam WW      = `DDROP_CHANNEL_COUNT * SAMPLE_BITS;
  localparam FIFO_AW = $clog2(FIFO_DEPTH);

  // Lane states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_ODD  = 3'b010;
  localparam ST_EVEN = 3'b100;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  // Sampling clock synchroniser and edge detector
  reg                  sync1_q;
  reg                  sync2_q;
  reg                  sync3_q;
  reg                  level_q;
  reg                  levelPrev_q;
  wire                 riseEvt;
  wire                 fallEvt;

  // Lane path state and next values
  reg  [2:0]           state_q;
  reg  [2:0]           state_d;
  reg  [WW-1:0]        hold_q;
  reg  [WW-1:0]        hold_d;
  reg  [PAIRS-1:0]     firstLanes_d;
  reg  [PAIRS-1:0]     secondLanes_d;

  // Buffer head and forwarded clock delay line
  wire [WW-1:0]        fifoData;
  wire                 fifoValid;
  wire [WW-1:0]        wordNow;
  reg  [SKEW_CYCLES:0] skew_q;

  // ----------------------------------------------------------------------------
  // Lane split helpers
  // ----------------------------------------------------------------------------
  // Odd bits of a word, pair k gets bit 2k+1
  function [PAIRS-1:0] oddBits;
    input [SAMPLE_BITS-1:0] w;
    integer k;
    begin
      for (k = 0; k < PAIRS; k = k + 1)
        oddBits[k] = w[2*k+1];
    end
  endfunction

  // Even bits of a word, pair k gets bit 2k
  function [PAIRS-1:0] evenBits;
    input [SAMPLE_BITS-1:0] w;
    integer k;
    begin
      for (k = 0; k < PAIRS; k = k + 1)
        evenBits[k] = w[2*k];
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------------------------
  // One word pair leaves per sampling rise
  // Channel two sits in the upper half of each entry
  ddrop_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) uFifo (
    .clk      (clk),
    .resetn   (resetn),
    .inData   ({secondChannelSample, firstChannelSample}),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (riseEvt)
  );

  // ----------------------------------------------------------------------------
  // Sampling clock recovery
  // ----------------------------------------------------------------------------
  // Three-stage sampling; level moves once stages two and three agree
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      sync1_q     <= 1'b0;
      sync2_q     <= 1'b0;
      sync3_q     <= 1'b0;
      level_q     <= 1'b0;
      levelPrev_q <= 1'b0;
    end
    else
    begin
      sync1_q     <= samplingClock;
      sync2_q     <= sync1_q;
      sync3_q     <= sync2_q;
      level_q     <= (sync2_q == sync3_q) ? sync3_q : level_q;
      levelPrev_q <= level_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Edge events
  // ----------------------------------------------------------------------------
  // Single-cycle strobes on each settled level change
  assign riseEvt = level_q & ~levelPrev_q;
  assign fallEvt = ~level_q & levelPrev_q;

  // Empty buffer falls back on the last word sent
  assign wordNow = fifoValid ? fifoData : hold_q;

  // ----------------------------------------------------------------------------
  // Lane next values
  // ----------------------------------------------------------------------------
  // Odd half on sampling rise, even half of same word on fall
  always @*
  begin
    state_d       = state_q;
    hold_d        = hold_q;
    firstLanes_d  = firstChannelBitPairs;
    secondLanes_d = secondChannelBitPairs;
    case (state_q)
      ST_IDLE, ST_EVEN:
      begin
        if (riseEvt)
        begin
          hold_d        = wordNow;
          firstLanes_d  = oddBits(wordNow[SAMPLE_BITS-1:0]);
          secondLanes_d = oddBits(wordNow[WW-1:SAMPLE_BITS]);
          state_d       = ST_ODD;
        end
      end
      ST_ODD:
      begin
        if (fallEvt)
        begin
          firstLanes_d  = evenBits(hold_q[SAMPLE_BITS-1:0]);
          secondLanes_d = evenBits(hold_q[WW-1:SAMPLE_BITS]);
          state_d       = ST_EVEN;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Lane registers
  // ----------------------------------------------------------------------------
  // Lanes and underrun strobe, all straight from flops
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q               <= ST_IDLE;
      hold_q                <= `DDROP_RST_WORD;
      firstChannelBitPairs  <= `DDROP_RST_LANES;
      secondChannelBitPairs <= `DDROP_RST_LANES;
      sampleUnderrun        <= 1'b0;
    end
    else
    begin
      state_q               <= state_d;
      hold_q                <= hold_d;
      firstChannelBitPairs  <= firstLanes_d;
      secondChannelBitPairs <= secondLanes_d;
      sampleUnderrun        <= riseEvt & ~fifoValid;
    end
  end

  // ----------------------------------------------------------------------------
  // Forwarded clock
  // ----------------------------------------------------------------------------
  // Inverted sampling level, delayed so edges sit mid-bit
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      skew_q             <= {(SKEW_CYCLES+1){1'b1}};
      forwardedWordClock <= 1'b1;
    end
    else
    begin
      skew_q             <= {skew_q[SKEW_CYCLES-1:0], ~level_q};
      forwardedWordClock <= skew_q[SKEW_CYCLES];
    end
  end

endmodule // ddrop_port

/* File: ddrop_map.vh */
// Constants of the dual-data-rate sample output port.
// Assumes a system clock of 100 MHz and a sampling clock well below half of it.
`ifndef DDROP_MAP_VH
`define DDROP_MAP_VH

// ----------------------------------------------------------------------------
// Word and lane layout
// ----------------------------------------------------------------------------
`define DDROP_SAMPLE_BITS   16
`define DDROP_PAIR_COUNT    8
`define DDROP_FIFO_DEPTH    16
`define DDROP_FIFO_AW       4
`define DDROP_CHANNEL_COUNT 2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DDROP_CLK_PERIOD_NS 10
// Lag of the forwarded clock behind the data change, less one clk period; a quarter of a 160 ns cycle
`define DDROP_SKEW_NS       40
`define DDROP_SKEW_CYCLES   (`DDROP_SKEW_NS / `DDROP_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DDROP_RST_LANES     8'h00
`define DDROP_RST_WORD      32'h0000_0000

`endif

/* File: ddrop_fifo.v */
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes both sides run on clk; reset is synchronous, active low.
`timescale 1ns/1ps
`include "ddrop_map.vh"

module ddrop_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = `DDROP_FIFO_DEPTH,
  parameter AW    = `DDROP_FIFO_AW
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output reg              inReady,
  output wire [WIDTH-1:0] outData,
  output reg              outValid,
  input  wire             outReady
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wrPtr_q;
  reg  [AW-1:0]    rdPtr_q;
  reg  [AW:0]      count_q;
  reg  [AW:0]      count_d;
  wire             push;
  wire             pop;

  // ----------------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------------
  assign push    = inValid & inReady;
  assign pop     = outValid & outReady;
  assign outData = mem[rdPtr_q];

  // Next fill level
  always @*
  begin
    count_d = count_q;
    if (push & ~pop)
      count_d = count_q + 1'b1;
    else if (pop & ~push)
      count_d = count_q - 1'b1;
  end

  // Storage without reset
  always @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end

  // Pointers and honest flags
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      wrPtr_q  <= {AW{1'b0}};
      rdPtr_q  <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
      inReady  <= 1'b0;
      outValid <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == DEPTH - 1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= (rdPtr_q == DEPTH - 1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      count_q  <= count_d;
      inReady  <= (count_d < DEPTH);
      outValid <= (count_d != {(AW+1){1'b0}});
    end
  end

endmodule // ddrop_fifo

/* File: ddrop_port_asserts.sv */
// Checker of forwarded clock and lane timing.
// Assumes a bind to ddrop_port, ports only.
`timescale 1ns/1ps
module ddrop_port_asserts #(
  parameter PAIRS = 8
) (
  input logic             clk,
  input logic             resetn,
  input logic             samplingClock,
  input logic             sampleReady,
  input logic [PAIRS-1:0] firstChannelBitPairs,
  input logic [PAIRS-1:0] secondChannelBitPairs,
  input logic             forwardedWordClock,
  input logic             sampleUnderrun
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ------
  // Rules
  // ------
  fwd_follow_a: assert property (
    $rose(samplingClock) |-> ##[6:13] $fell(forwardedWordClock))
    else $error("forwarded clock late");
  fwd_half_a: assert property (
    $changed(forwardedWordClock) |=> $stable(forwardedWordClock)[*6])
    else $error("forwarded clock half too short");
  lane_hold_a: assert property (
    $changed(forwardedWordClock) |->
      $stable({firstChannelBitPairs, secondChannelBitPairs})[*2])
    else $error("lanes move at clock edge");
  under_pulse_a: assert property (
    sampleUnderrun |=> !sampleUnderrun)
    else $error("underrun too long");
  ready_up_a: assert property (
    $rose(resetn) |=> sampleReady)
    else $error("ready late after reset");
endmodule // ddrop_port_asserts

bind ddrop_port ddrop_port_asserts #(.PAIRS(PAIRS)) i_ddrop_port_asserts (
  .clk(clk), .resetn(resetn), .samplingClock(samplingClock), .sampleReady(sampleReady),
  .firstChannelBitPairs(firstChannelBitPairs), .secondChannelBitPairs(secondChannelBitPairs),
  .forwardedWordClock(forwardedWordClock), .sampleUnderrun(sampleUnderrun));

/* File: ddrop_rx_model.sv */
// Receiver model: rebuilds both words.
// Assumes lanes and clock of ddrop_port.
`timescale 1ns/1ps
module ddrop_rx_model (
  input  logic        forwardedWordClock,
  input  logic [7:0]  firstChannelBitPairs,
  input  logic [7:0]  secondChannelBitPairs,
  output logic [15:0] rxFirst,
  output logic [15:0] rxSecond,
  output int          rxCount
);
  logic [7:0] oddFirst;
  logic [7:0] oddSecond;
  int         k;
  initial rxCount = 0;
  // Odd halves on the falling edge
  always @(negedge forwardedWordClock)
  begin
    oddFirst = firstChannelBitPairs;
    oddSecond = secondChannelBitPairs;
  end
  // Even halves on the rising edge
  always @(posedge forwardedWordClock)
  begin
    for (k = 0; k < 8; k++)
    begin
      rxFirst[2*k+1] = oddFirst[k];
      rxFirst[2*k] = firstChannelBitPairs[k];
      rxSecond[2*k+1] = oddSecond[k];
      rxSecond[2*k] = secondChannelBitPairs[k];
    end
    rxCount++;
  end
endmodule // ddrop_rx_model

/* File: ddrop_tb.sv */
// Testbench of the sample output port.
// Assumes ddrop_port and ddrop_rx_model.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam N = 24;
  logic        clk = 0;
  logic        resetn = 0;
  logic        samplingClock = 0;
  logic        sampleValid = 0;
  logic [15:0] firstChannelSample = 16'h0000;
  logic [15:0] secondChannelSample = 16'h0000;
  logic        refused = 0;
  logic        under = 0;
  wire         sampleReady, forwardedWordClock, sampleUnderrun;
  wire [7:0]   firstChannelBitPairs, secondChannelBitPairs;
  wire [15:0]  rxFirst, rxSecond;
  int          rxCount;
  int          failures = 0;
  int          n_checks = 0;
  ddrop_port i_ddrop_port (.clk(clk), .resetn(resetn), .samplingClock(samplingClock),
    .firstChannelSample(firstChannelSample), .secondChannelSample(secondChannelSample),
    .sampleValid(sampleValid), .sampleReady(sampleReady),
    .firstChannelBitPairs(firstChannelBitPairs), .secondChannelBitPairs(secondChannelBitPairs),
    .forwardedWordClock(forwardedWordClock), .sampleUnderrun(sampleUnderrun));
  ddrop_rx_model i_ddrop_rx_model (.forwardedWordClock(forwardedWordClock),
    .firstChannelBitPairs(firstChannelBitPairs), .secondChannelBitPairs(secondChannelBitPairs),
    .rxFirst(rxFirst), .rxSecond(rxSecond), .rxCount(rxCount));
  // ------
  // Clocks
  // ------
  always #5 clk = ~clk;
  initial
  begin
    #3.7;
    forever #80 samplingClock = ~samplingClock;
  end
  // Underrun catcher
  always @(posedge clk) if (sampleUnderrun === 1'b1) under <= 1'b1;
  function logic [15:0] wA(int i);
    return 16'h8000 ^ 16'(i * 16'h0b13);
  endfunction
  function logic [15:0] wB(int i);
    return 16'h4000 ^ 16'(i * 16'h1c25);
  endfunction
  // ------
  // Tasks
  // ------
  task test_done;
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task reset_dut;
    repeat (4) @(posedge clk);
    #1;
    `CHK(firstChannelBitPairs, 8'h00)
    `CHK(secondChannelBitPairs, 8'h00)
    `CHK(forwardedWordClock, 1'b1)
    `CHK(sampleUnderrun, 1'b0)
    `CHK(sampleReady, 1'b0)
    resetn = 1;
    @(posedge clk);
    #1;
    `CHK(sampleReady, 1'b1)
  endtask
  // Forwarded clock period equals sampling period
  task t_period;
    time t0;
    @(posedge forwardedWordClock);
    t0 = $time;
    @(posedge forwardedWordClock);
    `CHK($time - t0, 64'd160)
  endtask
  task push_all;
    #1;
    for (int i = 0; i < N; i++)
    begin
      bit took;
      took = 0;
      firstChannelSample = wA(i);
      secondChannelSample = wB(i);
      sampleValid = 1;
      repeat (100)
      begin
        @(posedge clk);
        if (sampleReady === 1'b1)
        begin
          took = 1;
          break;
        end
        refused = 1;
      end
      if (!took) failures++;
      #1;
    end
    sampleValid = 0;
  endtask
  // Back-to-back words through a full FIFO, then underrun
  task t_stream;
    fork
      push_all;
      begin
        repeat (60)
        begin
          @(rxCount);
          if (rxFirst === wA(0)) break;
        end
        `CHK(rxFirst, wA(0))
        `CHK(rxSecond, wB(0))
        for (int i = 1; i < N; i++)
        begin
          @(rxCount);
          `CHK(rxFirst, wA(i))
          `CHK(rxSecond, wB(i))
        end
      end
    join
    `CHK(refused, 1'b1)
    under = 0;
    repeat (3) @(rxCount);
    `CHK(under, 1'b1)
    `CHK(rxFirst, wA(N - 1))
    `CHK(rxSecond, wB(N - 1))
  endtask
  initial
  begin
    reset_dut;
    t_period;
    t_stream;
    test_done;
  end
  // Watchdog
  initial
  begin
    #100000;
    failures++;
    test_done;
  end
endmodule // testbench
